// File: hdl/cfm_charge_monitor.sv
/*
 charge fault monitor: apb register slave, qualification timers for over-voltage,
 over-current and depleted voltage, surplus charge tracking, switch controls and
 balancing gate.
 assumes:
 - measurement inputs, charger and discharge state are synchronous to pclk
 - meas_update pulses once per new measurement set
 - one second is a fixed count of pclk cycles
 - the apb master needs no wait states
// Overview of operation
// (R1) balance only while discharging flag clear
// (R2) min deviation zero disables balancing
// (R3) bypass time from capacity delta times deviation
// (R4) start over-voltage timer at limit reached
// (R5) drop below limit resets over-voltage timer
// (R6) over-voltage expiry flags, opens charge switches
// (R7) charge faults set alarm, zero requests
// (R8) clear over-voltage at or below request
// (R9) both qualification times default two seconds
// (R10) zero qualification time trips immediately
// (R11) over-current timer starts and resets likewise
// (R12) over-current expiry flags, opens charge switches
// (R13) clear over-current at recovery average current
// (R14) over-current margin defaults 500 mA
// (R15) depleted voltage flags, discharge alarm, switch
// (R16) depleted fault only with charger present
// (R17) depleted time two seconds, zero disables
// (R18) charging above recovery clears depleted fault
// (R19) keep counting charge beyond full capacity
// (R20) surplus limit flags, zeros requests, opens
// (R21) switch enables reset to zero
// (R22) timers count seconds, checked per measurement
*/
`timescale 1ns/100ps
`default_nettype none
`include "cfm_defines.svh"

module cfm_charge_monitor (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [11:0]        paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire cfm_pkg::cfm_meas_t meas,
   input  wire logic               meas_update,
   input  wire logic               charge_in,
   input  wire logic               discharging,
   input  wire logic               charger_present,
   input  wire logic [15:0]        cell_delta_mah,
   output logic                    charge_switch_on,
   output logic                    precharge_switch_on,
   output logic                    discharge_switch_on,
   output logic                    balance_on,
   output logic      [15:0]        req_volt_out,
   output logic      [15:0]        req_amp_out
);
   import cfm_pkg::*;

   // ==================================================
   // registers
   logic [3:0]  fault_cfg_reg;
   logic [15:0] req_volt_reg;
   logic [15:0] req_amp_reg;
   logic [15:0] ov_margin_reg;
   logic [15:0] oi_margin_reg;
   logic [15:0] oi_recov_reg;
   logic [7:0]  ov_time_reg;
   logic [7:0]  oi_time_reg;
   logic [7:0]  depl_time_reg;
   logic [15:0] depl_volt_reg;
   logic [15:0] depl_recov_reg;
   logic [15:0] oc_limit_reg;
   logic [15:0] min_dev_reg;
   logic [8:0]  status_reg;
   logic [31:0] surplus_reg;
   logic [31:0] sec_cnt_reg;
   logic        sec_tick;
   logic        ov_flag;
   logic        oi_flag;
   logic        depl_flag;
   logic        oc_flag;
   logic        wr_en;
   logic [31:0] rd_next;
   logic [31:0] bal_cnt_reg;

   assign wr_en   = psel & penable & pwrite;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~addr_ok(paddr);

   function automatic logic addr_ok(input logic [11:0] a);
      addr_ok = (a <= `CFM_OFF_SURPLUS) && (a[1:0] == 2'b00);
   endfunction

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_cfg_reg  <= `CFM_RST_FAULT_CFG; // R21
         req_volt_reg   <= 16'h0000;
         req_amp_reg    <= 16'h0000;
         ov_margin_reg  <= 16'h0000;
         oi_margin_reg  <= `CFM_RST_OI_MARGIN; // R14
         oi_recov_reg   <= `CFM_RST_OI_RECOV; // R13
         ov_time_reg    <= `CFM_RST_OV_TIME; // R9
         oi_time_reg    <= `CFM_RST_OI_TIME; // R9
         depl_time_reg  <= `CFM_RST_DEPL_TIME; // R17
         depl_volt_reg  <= 16'h0000;
         depl_recov_reg <= 16'h0000;
         oc_limit_reg   <= 16'h0000;
         min_dev_reg    <= `CFM_RST_MIN_DEV; // R3
      end else if (wr_en) begin
         case (paddr)
            `CFM_OFF_FAULT_CFG:  fault_cfg_reg  <= pwdata[3:0];
            `CFM_OFF_REQ_VOLT:   req_volt_reg   <= pwdata[15:0];
            `CFM_OFF_REQ_AMP:    req_amp_reg    <= pwdata[15:0];
            `CFM_OFF_OV_MARGIN:  ov_margin_reg  <= pwdata[15:0];
            `CFM_OFF_OI_MARGIN:  oi_margin_reg  <= pwdata[15:0];
            `CFM_OFF_OI_RECOV:   oi_recov_reg   <= pwdata[15:0];
            `CFM_OFF_TIMES: begin
               ov_time_reg   <= pwdata[7:0];
               oi_time_reg   <= pwdata[15:8];
               depl_time_reg <= pwdata[23:16];
            end
            `CFM_OFF_DEPL_VOLT:  depl_volt_reg  <= pwdata[15:0];
            `CFM_OFF_DEPL_RECOV: depl_recov_reg <= pwdata[15:0];
            `CFM_OFF_OC_LIMIT:   oc_limit_reg   <= pwdata[15:0];
            `CFM_OFF_MIN_DEV:    min_dev_reg    <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // ==================================================
   // read mux
   always_comb begin
      rd_next = 32'h0000_0000;
      case (paddr)
         `CFM_OFF_FAULT_CFG:  rd_next = {28'h0000000, fault_cfg_reg};
         `CFM_OFF_REQ_VOLT:   rd_next = {16'h0000, req_volt_reg};
         `CFM_OFF_REQ_AMP:    rd_next = {16'h0000, req_amp_reg};
         `CFM_OFF_OV_MARGIN:  rd_next = {16'h0000, ov_margin_reg};
         `CFM_OFF_OI_MARGIN:  rd_next = {16'h0000, oi_margin_reg};
         `CFM_OFF_OI_RECOV:   rd_next = {16'h0000, oi_recov_reg};
         `CFM_OFF_TIMES:      rd_next = {8'h00, depl_time_reg, oi_time_reg, ov_time_reg};
         `CFM_OFF_DEPL_VOLT:  rd_next = {16'h0000, depl_volt_reg};
         `CFM_OFF_DEPL_RECOV: rd_next = {16'h0000, depl_recov_reg};
         `CFM_OFF_OC_LIMIT:   rd_next = {16'h0000, oc_limit_reg};
         `CFM_OFF_MIN_DEV:    rd_next = {16'h0000, min_dev_reg};
         `CFM_OFF_STATUS:     rd_next = {23'h000000, status_reg};
         `CFM_OFF_CHG_OUT:    rd_next = {req_amp_out, req_volt_out};
         `CFM_OFF_SURPLUS:    rd_next = surplus_reg;
         default:             rd_next = 32'h0000_0000;
      endcase
   end

   // captured in setup so the data stands through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel & ~penable & ~pwrite) begin
         prdata <= rd_next;
      end
   end

   // ==================================================
   // one second time base
   // free running, so a timer's first second may be short
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sec_cnt_reg <= 32'h0000_0000;
      end else if (sec_tick) begin
         sec_cnt_reg <= 32'h0000_0000;
      end else begin
         sec_cnt_reg <= sec_cnt_reg + 32'h0000_0001;
      end
   end
   assign sec_tick = (sec_cnt_reg == 32'(`CFM_SEC_CYCLES - 1)); // R22

   // ==================================================
   // qualification timers
   logic [16:0] ov_limit;
   logic [16:0] oi_limit;
   logic        ov_cond;
   logic        oi_cond;
   logic        depl_cond;
   logic        ov_clear;
   logic        oi_clear;
   logic        depl_clear;
   logic [7:0]  ov_sec_reg;
   logic [7:0]  oi_sec_reg;
   // one bit wider so a 255 s time can still be exceeded
   logic [8:0]  depl_sec_reg;
   logic        depl_en;

   assign ov_limit   = {1'b0, req_volt_reg} + {1'b0, ov_margin_reg};
   assign oi_limit   = {1'b0, req_amp_reg} + {1'b0, oi_margin_reg};
   assign ov_cond    = {1'b0, meas.volt_mv} >= ov_limit; // R4
   assign oi_cond    = {1'b0, meas.amp_ma} >= oi_limit; // R11
   assign ov_clear   = meas.volt_mv <= req_volt_reg; // R8
   assign oi_clear   = meas.avg_amp_ma <= oi_recov_reg; // R13
   assign depl_en    = depl_time_reg != 8'h00; // R17
   assign depl_cond  = depl_en & charger_present & (meas.volt_mv <= depl_volt_reg); // R16
   assign depl_clear = ~discharging & (meas.volt_mv >= depl_recov_reg); // R18

   // over-voltage timer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ov_sec_reg <= 8'h00;
      end else if (meas_update & ~ov_cond) begin
         ov_sec_reg <= 8'h00; // R5
      end else if (ov_cond & sec_tick & ~ov_flag & (ov_sec_reg < ov_time_reg)) begin
         ov_sec_reg <= ov_sec_reg + 8'h01; // R22
      end
   end

   // set wins over clear in the same update
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ov_flag <= 1'b0;
      end else if (meas_update & ov_cond & (ov_sec_reg >= ov_time_reg)) begin
         ov_flag <= 1'b1; // R6 R10
      end else if (meas_update & ov_clear) begin
         ov_flag <= 1'b0; // R8
      end
   end

   // over-current timer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oi_sec_reg <= 8'h00;
      end else if (meas_update & ~oi_cond) begin
         oi_sec_reg <= 8'h00; // R11
      end else if (oi_cond & sec_tick & ~oi_flag & (oi_sec_reg < oi_time_reg)) begin
         oi_sec_reg <= oi_sec_reg + 8'h01;
      end
   end

   // set wins over clear here as well
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oi_flag <= 1'b0;
      end else if (meas_update & oi_cond & (oi_sec_reg >= oi_time_reg)) begin
         oi_flag <= 1'b1; // R12 R10
      end else if (meas_update & oi_clear) begin
         oi_flag <= 1'b0; // R13
      end
   end

   // depleted voltage timer; must stay low more than the set time
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         depl_sec_reg <= 9'h000;
      end else if (meas_update & ~depl_cond) begin
         depl_sec_reg <= 9'h000;
      end else if (depl_cond & sec_tick & ~depl_flag & (depl_sec_reg <= {1'b0, depl_time_reg})) begin
         depl_sec_reg <= depl_sec_reg + 9'h001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         depl_flag <= 1'b0;
      end else if (meas_update & depl_cond & (depl_sec_reg > {1'b0, depl_time_reg})) begin
         depl_flag <= 1'b1; // R15
      end else if (meas_update & depl_clear) begin
         depl_flag <= 1'b0; // R18
      end
   end

   // ==================================================
   // surplus charge beyond full capacity
   logic        at_full;
   logic        surplus_inc;
   logic        oc_hit;
   assign at_full     = meas.rem_cap_mah >= meas.full_capacity_value;
   assign surplus_inc = meas_update & charge_in & ~discharging;
   // judged on the count this update leaves, so the flag sets on reaching
   assign oc_hit      = at_full & ((surplus_reg + 32'(surplus_inc)) >= {16'h0000, oc_limit_reg});

   // cleared whenever capacity drops below full
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         surplus_reg <= 32'h0000_0000;
      end else if (!at_full) begin
         surplus_reg <= 32'h0000_0000;
      end else if (surplus_inc) begin
         surplus_reg <= surplus_reg + 32'h0000_0001; // R19
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oc_flag <= 1'b0;
      end else if (meas_update & oc_hit) begin
         oc_flag <= 1'b1; // R20 R22
      end else if (meas_update & !at_full) begin
         oc_flag <= 1'b0;
      end
   end

   // ==================================================
   // switches, alarms and request outputs
   logic        chg_open;
   logic        dsg_open;
   logic        terminate_charge_alarm;
   logic        terminate_discharge_alarm;
   assign chg_open = (ov_flag & fault_cfg_reg[`CFM_FC_OV_EN]) // R6
                   | (oi_flag & fault_cfg_reg[`CFM_FC_OI_EN]) // R12
                   | (oc_flag & fault_cfg_reg[`CFM_FC_OC_EN]); // R20
   assign dsg_open = depl_flag & fault_cfg_reg[`CFM_FC_DEPL_EN]; // R15
   assign terminate_charge_alarm      = ov_flag | oi_flag | oc_flag; // R7
   assign terminate_discharge_alarm      = depl_flag; // R15

   // reset closed: a fault opens a switch only while its enable is set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         charge_switch_on    <= 1'b1;
         precharge_switch_on <= 1'b1;
         discharge_switch_on <= 1'b1;
         req_volt_out        <= 16'h0000;
         req_amp_out         <= 16'h0000;
      end else begin
         charge_switch_on    <= ~chg_open;
         precharge_switch_on <= ~chg_open;
         discharge_switch_on <= ~dsg_open; // R18
         req_volt_out        <= terminate_charge_alarm ? 16'h0000 : req_volt_reg; // R7
         req_amp_out         <= terminate_charge_alarm ? 16'h0000 : req_amp_reg; // R7
      end
   end

   // ==================================================
   // cell balancing: bypass held for delta times deviation seconds
   logic bal_allow;
   assign bal_allow = ~discharging & (min_dev_reg != 16'h0000); // R1 R2

   // a new delta is taken only once the last bypass time ran out
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bal_cnt_reg <= 32'h0000_0000;
      end else if (!bal_allow) begin
         bal_cnt_reg <= 32'h0000_0000;
      end else if (meas_update & (bal_cnt_reg == 32'h0000_0000)) begin
         bal_cnt_reg <= 32'(cell_delta_mah) * 32'(min_dev_reg); // R3
      end else if (sec_tick & (bal_cnt_reg != 32'h0000_0000)) begin
         bal_cnt_reg <= bal_cnt_reg - 32'h0000_0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         balance_on <= 1'b0;
      end else begin
         balance_on <= bal_allow & (bal_cnt_reg != 32'h0000_0000); // R1
      end
   end

   // ==================================================
   // status word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_reg <= 9'h000;
      end else begin
         status_reg <= {balance_on, dsg_open, chg_open,
                        terminate_discharge_alarm, terminate_charge_alarm, oc_flag,
                        depl_flag, oi_flag, ov_flag};
      end
   end
endmodule
`default_nettype wire

// File: hdl/cfm_defines.svh
/*
 defines for the charge fault monitor: register byte offsets, field positions,
 reset values and timing counts. assumes a 50 MHz pclk.
*/
`ifndef CFM_DEFINES_SVH
`define CFM_DEFINES_SVH

`define CFM_CLK_HZ          50000000
`define CFM_SEC_CYCLES      (`CFM_CLK_HZ / 1)

`define CFM_OFF_CTRL        12'h000
`define CFM_OFF_FAULT_CFG   12'h004
`define CFM_OFF_REQ_VOLT    12'h008
`define CFM_OFF_REQ_AMP     12'h00c
`define CFM_OFF_OV_MARGIN   12'h010
`define CFM_OFF_OI_MARGIN   12'h014
`define CFM_OFF_OI_RECOV    12'h018
`define CFM_OFF_TIMES       12'h01c
`define CFM_OFF_DEPL_VOLT   12'h020
`define CFM_OFF_DEPL_RECOV  12'h024
`define CFM_OFF_OC_LIMIT    12'h028
`define CFM_OFF_MIN_DEV     12'h02c
`define CFM_OFF_STATUS      12'h030
`define CFM_OFF_CHG_OUT     12'h034
`define CFM_OFF_SURPLUS     12'h038

`define CFM_FC_OV_EN        0
`define CFM_FC_OI_EN        1
`define CFM_FC_OC_EN        2
`define CFM_FC_DEPL_EN      3

`define CFM_ST_OV           0
`define CFM_ST_OI           1
`define CFM_ST_DEPL         2
`define CFM_ST_OC           3
`define CFM_ST_TCA          4
`define CFM_ST_TDA          5
`define CFM_ST_CHG_OPEN     6
`define CFM_ST_DSG_OPEN     7
`define CFM_ST_BAL          8

`define CFM_RST_FAULT_CFG   4'h0
`define CFM_RST_OI_MARGIN   16'h01f4
`define CFM_RST_OI_RECOV    16'h0064
`define CFM_RST_OV_TIME     8'h02
`define CFM_RST_OI_TIME     8'h02
`define CFM_RST_DEPL_TIME   8'h02
`define CFM_RST_MIN_DEV     16'h06d6

`endif

// File: hdl/cfm_pkg.sv
/*
 types for the charge fault monitor.
 assumes cfm_defines.svh is available to users.
*/
`default_nettype none
package cfm_pkg;
   typedef struct packed {
      logic [15:0] volt_mv;
      logic [15:0] amp_ma;
      logic [15:0] avg_amp_ma;
      logic [15:0] rem_cap_mah;
      logic [15:0] full_capacity_value;
   } cfm_meas_t;

   typedef enum logic [1:0] {
      CFM_Q_IDLE,
      CFM_Q_RUN,
      CFM_Q_FAULT
   } cfm_qual_t;
endpackage
`default_nettype wire

// File: tb/cfm_afe_model.sv
/*
 far side stand-in: measurement source, charger and pack state.
 assumes pclk from the bench; signals change after rising edges.
*/
`timescale 1ns/100ps
`default_nettype none
module cfm_afe_model import cfm_pkg::*; (
   input  wire logic         pclk,
   output var  cfm_meas_t    meas,
   output var  logic         meas_update,
   output var  logic         charge_in,
   output var  logic         discharging,
   output var  logic         charger_present,
   output var  logic [15:0]  cell_delta_mah
);
   initial begin
      meas = '0;
      meas_update = 1'b0;
      charge_in = 1'b0;
      discharging = 1'b0;
      charger_present = 1'b1;
      cell_delta_mah = 16'h0;
   end
   // ==========================================
   // one measurement set, update one cycle wide
   task automatic sample(input logic [15:0] v, a, g, r, f, input logic c);
      @(posedge pclk);
      meas <= '{v, a, g, r, f};
      charge_in <= c;
      meas_update <= 1'b1;
      @(posedge pclk);
      meas_update <= 1'b0;
      charge_in <= 1'b0;
   endtask
endmodule
`default_nettype wire

// File: tb/cfm_charge_monitor_tb.sv
/*
 testbench for the charge fault monitor: apb master, scenarios, verdict.
 assumes the model and checker files are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "cfm_defines.svh"
module cfm_charge_monitor_tb;
   import cfm_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, balance_on;
   logic meas_update, charge_in, discharging, charger_present;
   logic charge_switch_on, precharge_switch_on, discharge_switch_on;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] cell_delta_mah, req_volt_out, req_amp_out;
   cfm_meas_t   meas;
   int errors = 0;
   int checks = 0;
   cfm_afe_model afe (.pclk, .meas, .meas_update, .charge_in, .discharging, .charger_present, .cell_delta_mah);
   cfm_charge_monitor dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .meas, .meas_update, .charge_in, .discharging, .charger_present, .cell_delta_mah,
      .charge_switch_on, .precharge_switch_on, .discharge_switch_on, .balance_on, .req_volt_out, .req_amp_out);
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // ==========================================
   // helpers
   task automatic results();
      if (errors == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic bad(input string m);
      errors++;
      $display("BAD %0t %s", $time, m);
   endtask
   task automatic cmp(input logic [31:0] g, x, input string m);
      checks++;
      if (g !== x) bad(m);
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         bad("apb hang");
         results();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] q);
      logic e;
      apb(1'b0, a, 32'h0, q, e);
   endtask
   task automatic sbit(input int b, input logic x, input string m);
      logic [31:0] q;
      rd(`CFM_OFF_STATUS, q);
      cmp(q[b], x, m);
   endtask
   task automatic step(input logic [15:0] v, a, g, r, input logic c);
      afe.sample(v, a, g, r, 16'h03e8, c);
      @(posedge pclk);
      #1;
   endtask
   // ==========================================
   // scenarios
   task automatic t_reset_values();
      logic [11:0] a [5] = '{`CFM_OFF_FAULT_CFG, `CFM_OFF_OI_MARGIN, `CFM_OFF_OI_RECOV, `CFM_OFF_TIMES, `CFM_OFF_MIN_DEV};
      logic [31:0] x [5] = '{32'h0, 32'h1f4, 32'h64, 32'h020202, 32'h6d6};
      logic [31:0] q;
      logic e;
      for (int i = 0; i < 5; i++) begin
         rd(a[i], q);
         cmp(q, x[i], "reset value");
      end
      apb(1'b0, 12'h03c, 32'h0, q, e);
      cmp(e, 32'h1, "unmapped no error");
      cmp(q, 32'h0, "unmapped data");
   endtask
   task automatic t_balance();
      @(posedge pclk);
      afe.cell_delta_mah <= 16'h0005;
      step(16'h0fa0, 16'h0, 16'h0, 16'h01f4, 1'b0);
      cmp(balance_on, 32'h1, "no balancing");
      @(posedge pclk);
      afe.discharging <= 1'b1;
      step(16'h0fa0, 16'h0, 16'h0, 16'h01f4, 1'b0);
      cmp(balance_on, 32'h0, "balancing in discharge");
      @(posedge pclk);
      afe.discharging <= 1'b0;
      wr(`CFM_OFF_MIN_DEV, 32'h0);
      step(16'h0fa0, 16'h0, 16'h0, 16'h01f4, 1'b0);
      cmp(balance_on, 32'h0, "balancing at zero deviation");
   endtask
   task automatic t_over_volt();
      wr(`CFM_OFF_REQ_VOLT, 32'h1068);
      wr(`CFM_OFF_REQ_AMP, 32'h3e8);
      wr(`CFM_OFF_OV_MARGIN, 32'h64);
      wr(`CFM_OFF_DEPL_VOLT, 32'h1000);
      wr(`CFM_OFF_FAULT_CFG, 32'hf);
      wr(`CFM_OFF_TIMES, 32'h0);
      step(16'h10cb, 16'h0, 16'h0, 16'h01f4, 1'b0);
      sbit(`CFM_ST_OV, 1'b0, "ov below limit");
      step(16'h10cc, 16'h0, 16'h0, 16'h01f4, 1'b0);
      cmp({charge_switch_on, precharge_switch_on}, 32'h0, "switches closed");
      cmp({req_volt_out, req_amp_out}, 32'h0, "requests kept");
      sbit(`CFM_ST_OV, 1'b1, "ov not set");
      sbit(`CFM_ST_TCA, 1'b1, "alarm not set");
      step(16'h1069, 16'h0, 16'h0, 16'h01f4, 1'b0);
      sbit(`CFM_ST_OV, 1'b1, "ov cleared early");
      step(16'h1068, 16'h0, 16'h0, 16'h01f4, 1'b0);
      sbit(`CFM_ST_OV, 1'b0, "ov not cleared");
   endtask
   task automatic t_over_amp();
      step(16'h0fa0, 16'h05db, 16'h05db, 16'h01f4, 1'b0);
      sbit(`CFM_ST_OI, 1'b0, "oi below limit");
      step(16'h0fa0, 16'h05dc, 16'h05dc, 16'h01f4, 1'b0);
      cmp(charge_switch_on, 32'h0, "oi switch closed");
      sbit(`CFM_ST_OI, 1'b1, "oi not set");
      step(16'h0fa0, 16'h0, 16'h0065, 16'h01f4, 1'b0);
      sbit(`CFM_ST_OI, 1'b1, "oi cleared early");
      step(16'h0fa0, 16'h0, 16'h0064, 16'h01f4, 1'b0);
      sbit(`CFM_ST_OI, 1'b0, "oi not cleared");
      sbit(`CFM_ST_DEPL, 1'b0, "depleted with zero time");
      cmp(discharge_switch_on, 32'h1, "discharge opened");
   endtask
   task automatic t_surplus();
      logic [31:0] q;
      int n;
      wr(`CFM_OFF_OC_LIMIT, 32'h3);
      step(16'h0fa0, 16'h0, 16'h0, 16'h03e8, 1'b1);
      rd(`CFM_OFF_SURPLUS, q);
      cmp(q != 32'h0, 32'h1, "surplus not counted");
      n = 0;
      do begin
         step(16'h0fa0, 16'h0, 16'h0, 16'h03e8, 1'b1);
         rd(`CFM_OFF_STATUS, q);
         n++;
      end while (q[`CFM_ST_OC] !== 1'b1 && n < 8);
      cmp(q[`CFM_ST_OC], 32'h1, "surplus flag");
      cmp({req_volt_out, charge_switch_on}, 32'h0, "surplus outputs");
   endtask
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_reset_values();
      t_balance();
      t_over_volt();
      t_over_amp();
      t_surplus();
      results();
   end
   initial begin
      repeat (60000) @(posedge pclk);
      bad("run hang");
      results();
   end
endmodule
`default_nettype wire

// File: tb/cfm_rules_monitor.sv
/*
 port checker for the charge fault monitor.
 assumes one pclk domain and the active low async presetn.
*/
`timescale 1ns/100ps
`default_nettype none
module cfm_rules_monitor (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        meas_update,
   input wire logic        discharging,
   input wire logic        charger_present,
   input wire logic        charge_switch_on,
   input wire logic        precharge_switch_on,
   input wire logic        discharge_switch_on,
   input wire logic        balance_on,
   input wire logic [15:0] req_volt_out,
   input wire logic [15:0] req_amp_out
);
   // ==========================================
   // checks
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_rd_setup; psel && !penable && !pwrite; endsequence
   sequence s_access; psel && penable; endsequence
   chk_ready_access: assert property (s_access |-> pready)
      else $error("pready low in access");
   chk_err_unmapped: assert property (s_access ##0 paddr > 12'h038 |-> pslverr)
      else $error("no error on unmapped");
   chk_err_mapped: assert property (s_access ##0 (paddr <= 12'h038 && paddr[1:0] == 2'b00) |-> !pslverr)
      else $error("error on mapped");
   chk_rdata_stands: assert property (s_rd_setup ##1 s_access |=> $stable(prdata))
      else $error("read data moved");
   chk_bal_charging: assert property (discharging |=> !balance_on)
      else $error("balancing while discharging");
   chk_pair_open: assert property ($fell(precharge_switch_on) |-> !charge_switch_on)
      else $error("precharge opened alone");
   chk_req_zeroed: assert property ($fell(charge_switch_on) |-> req_volt_out == 16'h0 && req_amp_out == 16'h0)
      else $error("requests not zeroed");
   chk_sw_on_update: assert property ($changed(charge_switch_on) || $changed(discharge_switch_on) |-> $past(meas_update) || $past(meas_update, 2))
      else $error("switch moved without update");
   chk_dsg_charger: assert property ($fell(discharge_switch_on) |-> $past(charger_present, 2))
      else $error("depleted trip without charger");
endmodule
bind cfm_charge_monitor cfm_rules_monitor u_rules (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
   .pready, .pslverr, .meas_update, .discharging, .charger_present, .charge_switch_on, .precharge_switch_on,
   .discharge_switch_on, .balance_on, .req_volt_out, .req_amp_out);
`default_nettype wire
